// [rtl/dat_cfg.svh]
// Purpose: timing figures and constants shared by both link ends
// Assumes: local clock period DAT_CLK_NS, link clock made by the host divider
// Notes: nCK figures count link clock periods, ns figures convert to local cycles
`ifndef DAT_CFG_SVH
`define DAT_CFG_SVH
`define DAT_CLK_NS 20
`define DAT_CK_HALF 4
`define DAT_PL_NCK 4
`define DAT_PAR_EXTRA_NS 6
`define DAT_PAR_EXTRA_CYC (((`DAT_PAR_EXTRA_NS / `DAT_CLK_NS) < 1) ? 1 : (`DAT_PAR_EXTRA_NS / `DAT_CLK_NS))
`define DAT_WLMRD_NCK 40
`define DAT_WLDQSEN_NCK 25
`define DAT_PAR_PW_LO_MIN 48
`define DAT_PAR_PW_LO_MAX 96
`define DAT_PAR_PW_HI_MIN 56
`define DAT_PAR_PW_HI_MAX 112
`define DAT_PAR_RSP_LO 43
`define DAT_PAR_RSP_HI 50
`define DAT_CRC_DLY_MIN_NS 3
`define DAT_CRC_DLY_MAX_NS 13
`define DAT_CRC_DLY_MIN_CYC ((`DAT_CRC_DLY_MIN_NS + `DAT_CLK_NS - 1) / `DAT_CLK_NS)
`define DAT_CRC_DLY_MAX_CYC (((`DAT_CRC_DLY_MAX_NS / `DAT_CLK_NS) < 1) ? 1 : (`DAT_CRC_DLY_MAX_NS / `DAT_CLK_NS))
`define DAT_CRC_PW_MIN 6
`define DAT_CRC_PW_MAX 10
`define DAT_CRC_PW_DEF 8
`define DAT_CRC_POLY 8'h07
`endif

// [rtl/dat_pkg.sv]
// Purpose: types shared by both ends of the alert and leveling link
// Assumes: nothing beyond the config header
// Notes: command codes travel on the three command wires
package dat_pkg;
	typedef enum logic [2:0] {
		CMD_DES = 3'h0,
		CMD_WL_ON = 3'h1,
		CMD_WL_OFF = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_NOP = 3'h4
	} dat_cmd_e;
	typedef enum logic [1:0] {DS_IDLE, DS_WAIT, DS_PAR, DS_CRC} dat_dstate_e;
	typedef enum logic [1:0] {HS_IDLE, HS_WL_WAIT, HS_WL_RUN} dat_hstate_e;
	function automatic logic [7:0] dat_crc8(input logic [7:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 7; i >= 0; i--)
		begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction : dat_crc8
endpackage : dat_pkg

// [rtl/dat_link_if.sv]
// Purpose: link wires between host controller end and memory device end
// Assumes: alert is open drain with pull-up, strobe gated by its enable
// Notes: enables are active low
`timescale 1ns/100ps
interface dat_link_if;
	logic ck;
	logic dqs;
	logic dqs_oe_n;
	logic dqs_line;
	logic par;
	logic [2:0] cmd;
	logic [7:0] wdata;
	logic [7:0] wcrc;
	logic dq_fb;
	logic alert_o;
	logic alert_oe_n;
	logic alert_n;
	assign alert_n = alert_oe_n ? 1'b1 : alert_o;
	assign dqs_line = dqs_oe_n ? 1'b0 : dqs;
	modport host (
		output ck, dqs, dqs_oe_n, par, cmd, wdata, wcrc,
		input dq_fb, alert_n
	);
	modport dev (
		input ck, dqs_line, par, cmd, wdata, wcrc,
		output dq_fb, alert_o, alert_oe_n
	);
endinterface : dat_link_if

// [rtl/dat_dev_end.sv]
// Purpose: memory device end: parity and write check alerts, write leveling
// Assumes: all link inputs come from another clock and are synchronised here
// Notes: link clock edges are found by sampling ck on i_clock
// How it works
// - Host waits 40 nCK before first strobe
// - Host waits 25 nCK before strobe enable
// - Commands inside parity latency after error dropped
// - Parity alert within parity latency plus 6ns
// - Parity alert held 48..96 or 56..112 nCK
// - Persistent mode host sends DES promptly
// - Write check alert within 3..13 ns; device raises it one 20 ns local cycle after the failed check
// - Write check alert held 6..10 nCK
`timescale 1ns/100ps
`include "dat_cfg.svh"
module dat_dev_end #(
	parameter int PAR_PW = `DAT_PAR_PW_LO_MIN,
	parameter int CRC_PW = `DAT_CRC_PW_DEF
) (
	input wire logic i_clock, // Local clock
	input wire logic i_rst_n, // Async reset
	input wire logic i_persist, // Persistent parity mode
	dat_link_if.dev lnk, // Link to host
	output logic o_wl_mode, // Leveling mode active
	output logic o_wr_valid, // Good write pulse
	output logic [7:0] o_wr_data, // Good write data
	output logic o_par_err, // Parity error pulse
	output logic o_crc_err, // Write check error pulse
	output logic o_alert // Alert being driven
);
	typedef struct packed {
		logic ck_s1;
		logic ck_s2;
		logic ck_d;
		logic dqs_s1;
		logic dqs_s2;
		logic dqs_d;
		logic [2:0] cmd_s1;
		logic [2:0] cmd_s2;
		logic par_s1;
		logic par_s2;
		logic [7:0] wd_s1;
		logic [7:0] wd_s2;
		logic [7:0] wc_s1;
		logic [7:0] wc_s2;
		dat_pkg::dat_dstate_e st;
		logic [6:0] cnt;
		logic wl;
		logic fb;
		logic alert_o;
		logic alert_oe_n;
		logic wr_valid;
		logic [7:0] wr_data;
		logic par_err;
		logic crc_err;
		logic alert;
	} dat_dev_s;

	localparam dat_dev_s RST = '{
		st: dat_pkg::DS_IDLE,
		alert_oe_n: 1'b1,
		default: '0
	};

	dat_dev_s r_reg;
	dat_dev_s r_next;
	logic ck_rise;
	logic dqs_rise;
	logic par_bad;
	logic crc_ok;
	logic take;
	logic par_hit;
	logic exec;

	assign ck_rise = r_reg.ck_s2 & ~r_reg.ck_d;
	assign dqs_rise = r_reg.dqs_s2 & ~r_reg.dqs_d;
	// Even parity over command and parity wires
	assign par_bad = ^{r_reg.cmd_s2, r_reg.par_s2};
	assign crc_ok = dat_pkg::dat_crc8(r_reg.wd_s2) == r_reg.wc_s2;
	// Nothing is taken inside the uncertain window after an errant command
	assign take = ck_rise && (r_reg.st != dat_pkg::DS_WAIT)
		&& !((r_reg.st == dat_pkg::DS_PAR) && i_persist
		&& (r_reg.cmd_s2 != dat_pkg::CMD_DES));
	assign par_hit = take && par_bad;
	assign exec = take && !par_bad;

	always_comb
	begin
		r_next = r_reg;
		r_next.ck_s1 = lnk.ck;
		r_next.ck_s2 = r_reg.ck_s1;
		r_next.ck_d = r_reg.ck_s2;
		r_next.dqs_s1 = lnk.dqs_line;
		r_next.dqs_s2 = r_reg.dqs_s1;
		r_next.dqs_d = r_reg.dqs_s2;
		r_next.cmd_s1 = lnk.cmd;
		r_next.cmd_s2 = r_reg.cmd_s1;
		r_next.par_s1 = lnk.par;
		r_next.par_s2 = r_reg.par_s1;
		r_next.wd_s1 = lnk.wdata;
		r_next.wd_s2 = r_reg.wd_s1;
		r_next.wc_s1 = lnk.wcrc;
		r_next.wc_s2 = r_reg.wc_s1;
		r_next.wr_valid = 1'b0;
		r_next.par_err = 1'b0;
		r_next.crc_err = 1'b0;
		r_next.alert_o = 1'b0;
		// Both strobe and clock pass the same two stages, so phase is kept
		if (dqs_rise && r_reg.wl)
		begin
			r_next.fb = r_reg.ck_s2;
		end
		if (ck_rise)
		begin
			unique case (r_reg.st)
				dat_pkg::DS_IDLE:
				begin
					r_next.alert_oe_n = 1'b1;
				end
				dat_pkg::DS_WAIT:
				begin
					// Edge lag of a few local cycles keeps this inside PL plus 6ns
					if (r_reg.cnt == 7'h01)
					begin
						r_next.st = dat_pkg::DS_PAR;
						r_next.cnt = 7'(PAR_PW);
						r_next.alert_oe_n = 1'b0;
					end
					else
					begin
						r_next.cnt = r_reg.cnt - 7'h01;
					end
				end
				dat_pkg::DS_PAR:
				begin
					if (r_reg.cnt == 7'h01)
					begin
						r_next.st = dat_pkg::DS_IDLE;
						r_next.alert_oe_n = 1'b1;
					end
					else
					begin
						r_next.cnt = r_reg.cnt - 7'h01;
					end
				end
				dat_pkg::DS_CRC:
				begin
					if (r_reg.cnt == 7'h01)
					begin
						r_next.st = dat_pkg::DS_IDLE;
						r_next.alert_oe_n = 1'b1;
					end
					else
					begin
						r_next.cnt = r_reg.cnt - 7'h01;
					end
				end
			endcase
		end
		// A parity error during its own alert only drops the command
		if (par_hit && (r_reg.st != dat_pkg::DS_PAR))
		begin
			r_next.st = dat_pkg::DS_WAIT;
			r_next.cnt = 7'(`DAT_PL_NCK - 1);
			r_next.alert_oe_n = 1'b1;
			r_next.par_err = 1'b1;
		end
		if (exec)
		begin
			unique case (r_reg.cmd_s2)
				dat_pkg::CMD_WL_ON:
				begin
					r_next.wl = 1'b1;
				end
				dat_pkg::CMD_WL_OFF:
				begin
					r_next.wl = 1'b0;
					r_next.fb = 1'b0;
				end
				dat_pkg::CMD_WRITE:
				begin
					if (crc_ok)
					begin
						r_next.wr_valid = 1'b1;
						r_next.wr_data = r_reg.wd_s2;
					end
					else
					begin
						r_next.crc_err = 1'b1;
						// Alert lands one local cycle later, the least whole cycle
						if (r_reg.st != dat_pkg::DS_PAR)
						begin
							r_next.st = dat_pkg::DS_CRC;
							r_next.cnt = 7'(CRC_PW);
							r_next.alert_oe_n = 1'b0;
						end
					end
				end
				default:
				begin
					r_next.wl = r_reg.wl;
				end
			endcase
		end
		r_next.alert = ~r_next.alert_oe_n;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			r_reg <= RST;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign lnk.dq_fb = r_reg.fb;
	assign lnk.alert_o = r_reg.alert_o;
	assign lnk.alert_oe_n = r_reg.alert_oe_n;
	assign o_wl_mode = r_reg.wl;
	assign o_wr_valid = r_reg.wr_valid;
	assign o_wr_data = r_reg.wr_data;
	assign o_par_err = r_reg.par_err;
	assign o_crc_err = r_reg.crc_err;
	assign o_alert = r_reg.alert;
endmodule : dat_dev_end

// [rtl/dat_host_end.sv]
// Purpose: host controller end: link clock, commands, leveling strobe
// Assumes: alert and leveling feedback arrive from another clock domain
// Notes: commands change on the falling link clock edge
`timescale 1ns/100ps
`include "dat_cfg.svh"
module dat_host_end (
	input wire logic i_clock, // Local clock
	input wire logic i_rst_n, // Async reset
	input wire logic i_cmd_valid, // Command request
	input wire logic [2:0] i_cmd, // Command code
	input wire logic [7:0] i_wdata, // Write data
	input wire logic i_bad_par, // Inject parity error
	input wire logic i_bad_crc, // Inject check error
	input wire logic i_persist, // Persistent parity mode
	input wire logic [2:0] i_wl_phase, // Strobe phase in link period
	dat_link_if.host lnk, // Link to device
	output logic o_cmd_ready, // Command taken pulse
	output logic o_alert, // Alert seen low
	output logic o_fb_valid, // Leveling sample pulse
	output logic o_fb, // Leveling sample
	output logic o_wl_run // Leveling strobes running
);
	typedef struct packed {
		logic [2:0] ph;
		logic ck;
		logic dqs;
		logic dqs_oe_n;
		logic [2:0] cmd;
		logic par;
		logic [7:0] wdata;
		logic [7:0] wcrc;
		dat_pkg::dat_hstate_e st;
		logic [5:0] ncnt;
		logic al_s1;
		logic al_s2;
		logic fb_s1;
		logic fb_s2;
		logic ready;
		logic alert;
		logic fb_valid;
		logic fb;
		logic wl_run;
	} dat_host_s;

	localparam dat_host_s RST = '{
		st: dat_pkg::HS_IDLE,
		dqs_oe_n: 1'b1,
		al_s1: 1'b1,
		al_s2: 1'b1,
		default: '0
	};

	dat_host_s r_reg;
	dat_host_s r_next;
	logic [2:0] ph_n;
	logic fall;
	logic block;
	logic accept;

	assign ph_n = 3'(r_reg.ph + 3'h1);
	assign fall = ph_n == 3'(`DAT_CK_HALF);
	// Holding DES from the next falling edge meets the response deadline
	assign block = (r_reg.st == dat_pkg::HS_WL_WAIT) || (i_persist && !r_reg.al_s2);
	assign accept = fall && i_cmd_valid && !block;

	always_comb
	begin
		r_next = r_reg;
		r_next.ph = ph_n;
		r_next.ck = ph_n < 3'(`DAT_CK_HALF);
		r_next.al_s1 = lnk.alert_n;
		r_next.al_s2 = r_reg.al_s1;
		r_next.fb_s1 = lnk.dq_fb;
		r_next.fb_s2 = r_reg.fb_s1;
		r_next.alert = !r_reg.al_s2;
		r_next.ready = accept;
		r_next.fb_valid = 1'b0;
		if (fall)
		begin
			r_next.cmd = dat_pkg::CMD_DES;
			r_next.par = 1'b0;
			if (r_reg.st == dat_pkg::HS_WL_WAIT)
			begin
				r_next.ncnt = 6'(r_reg.ncnt + 6'h01);
				// Count starts half a period before the device samples the command
				if (r_reg.ncnt + 6'h01 >= 6'(`DAT_WLDQSEN_NCK + 1))
				begin
					r_next.dqs_oe_n = 1'b0;
				end
				if (r_reg.ncnt + 6'h01 >= 6'(`DAT_WLMRD_NCK + 1))
				begin
					r_next.st = dat_pkg::HS_WL_RUN;
				end
			end
		end
		if (accept)
		begin
			r_next.cmd = i_cmd;
			r_next.par = ^i_cmd ^ i_bad_par;
			r_next.wdata = i_wdata;
			r_next.wcrc = dat_pkg::dat_crc8(i_wdata) ^ {7'h00, i_bad_crc};
			if (i_cmd == dat_pkg::CMD_WL_ON)
			begin
				r_next.st = dat_pkg::HS_WL_WAIT;
				r_next.ncnt = 6'h00;
			end
			else if (i_cmd == dat_pkg::CMD_WL_OFF)
			begin
				r_next.st = dat_pkg::HS_IDLE;
				r_next.dqs_oe_n = 1'b1;
			end
		end
		// Strobe high for half a period starting at the chosen phase
		if (r_next.st == dat_pkg::HS_WL_RUN)
		begin
			r_next.dqs = 3'(ph_n - i_wl_phase) < 3'(`DAT_CK_HALF);
		end
		else
		begin
			r_next.dqs = 1'b0;
		end
		// Sample reported is from the previous strobe edge
		if ((r_reg.st == dat_pkg::HS_WL_RUN) && (ph_n == i_wl_phase))
		begin
			r_next.fb_valid = 1'b1;
			r_next.fb = r_reg.fb_s2;
		end
		r_next.wl_run = r_next.st == dat_pkg::HS_WL_RUN;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			r_reg <= RST;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign lnk.ck = r_reg.ck;
	assign lnk.dqs = r_reg.dqs;
	assign lnk.dqs_oe_n = r_reg.dqs_oe_n;
	assign lnk.cmd = r_reg.cmd;
	assign lnk.par = r_reg.par;
	assign lnk.wdata = r_reg.wdata;
	assign lnk.wcrc = r_reg.wcrc;
	assign o_cmd_ready = r_reg.ready;
	assign o_alert = r_reg.alert;
	assign o_fb_valid = r_reg.fb_valid;
	assign o_fb = r_reg.fb;
	assign o_wl_run = r_reg.wl_run;
endmodule : dat_host_end

// [dv/dat_link_sva.sv]
// Purpose: link timing checker for alerts and leveling
// Assumes: 8 local cycles per link clock period
// Notes: ns limits rounded up to whole local cycles
`timescale 1ns/100ps
module dat_link_sva (
	input wire logic i_clock, // Local clock
	input wire logic i_rst_n, // Async reset
	input wire logic i_persist, // Persistent mode
	input wire logic ck, // Link clock
	input wire logic dqs_line, // Strobe level
	input wire logic dqs_oe_n, // Strobe enable
	input wire logic par, // Command parity
	input wire logic [2:0] cmd, // Command code
	input wire logic alert_o, // Alert value
	input wire logic alert_oe_n, // Alert enable
	input wire logic alert_n // Alert level
);
	typedef struct packed {
		logic [2:0] cmd;
		logic [9:0] lo;
		logic [9:0] wl;
		logic seen;
	} dat_chk_s;
	dat_chk_s st_reg;
	dat_chk_s st_next;
	// Saturating counts, so a stuck alert still fails
	always_comb
	begin
		st_next = st_reg;
		st_next.cmd = cmd;
		st_next.lo = alert_n ? 10'h000 : st_reg.lo + {9'h000, st_reg.lo != 10'h3FF};
		st_next.wl = st_reg.wl + {9'h000, st_reg.wl != 10'h3FF};
		st_next.seen = st_reg.seen | dqs_line;
		if (cmd == dat_pkg::CMD_WL_ON && st_reg.cmd != dat_pkg::CMD_WL_ON)
		begin
			st_next.wl = 10'h000;
			st_next.seen = 1'b0;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	a_alert_drive_low: assert property (!alert_oe_n |-> !alert_o && !alert_n)
		else $error("alert enabled but line high");
	// Count runs from the command change, half a period before it is sampled
	a_level_en_wait: assert property ($fell(dqs_oe_n) |-> st_reg.wl >= 10'h0CC)
		else $error("strobe enabled too early");
	a_level_first_strobe: assert property ($rose(dqs_line) && !st_reg.seen |-> st_reg.wl >= 10'h144)
		else $error("first strobe too early");
	a_par_alert_delay: assert property ($rose(ck) && (par != ^cmd) && alert_n |-> ##[1:33] !alert_n)
		else $error("parity alert late");
	a_par_pulse_len: assert property ($rose(alert_n) && st_reg.lo >= 10'h0C8 |-> st_reg.lo >= 10'h180 && st_reg.lo <= 10'h300)
		else $error("parity alert width");
	a_crc_pulse_len: assert property ($rose(alert_n) && st_reg.lo < 10'h0C8 |-> st_reg.lo >= 10'h030 && st_reg.lo <= 10'h050)
		else $error("write check alert width");
	a_alert_max_len: assert property (st_reg.lo <= 10'h300)
		else $error("alert held too long");
	a_persist_des: assert property (i_persist && $fell(alert_n) |-> ##[0:344] cmd == dat_pkg::CMD_DES)
		else $error("no idle commands after alert");
	c_crc_alert: cover property ($rose(alert_n) && st_reg.lo < 10'h0C8);
	c_par_alert: cover property ($rose(alert_n) && st_reg.lo >= 10'h0C8);
	c_strobe: cover property ($rose(dqs_line) && !st_reg.seen);
endmodule : dat_link_sva

// [dv/dram_alert_and_leveling_timing_test.sv]
// Purpose: bench joining host and device ends of the link
// Assumes: 50 MHz local clock, link clock from the host divider
// Notes: device events are matched in order against a queue
`timescale 1ns/100ps
module dram_alert_and_leveling_timing_test;
	logic i_clock;
	logic i_rst_n;
	logic cmd_valid, bad_par, bad_crc, persist, crc_pend;
	logic [2:0] cmd;
	logic [2:0] wl_phase;
	logic [7:0] wdata;
	logic [7:0] d;
	logic cmd_ready, h_alert, fb_valid, fb, wl_run;
	logic wl_mode, wr_valid, par_err, crc_err, d_alert;
	logic [7:0] wr_data;
	logic [9:0] got;
	logic [9:0] exp_q[$];
	int err_count;
	int total_checks;
	int cyc;
	dat_link_if lnk ();
	dat_host_end u_dat_host_end (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cmd_valid(cmd_valid),
		.i_cmd(cmd), .i_wdata(wdata), .i_bad_par(bad_par), .i_bad_crc(bad_crc),
		.i_persist(persist), .i_wl_phase(wl_phase), .lnk(lnk), .o_cmd_ready(cmd_ready),
		.o_alert(h_alert), .o_fb_valid(fb_valid), .o_fb(fb), .o_wl_run(wl_run));
	dat_dev_end u_dat_dev_end (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_persist(persist),
		.lnk(lnk), .o_wl_mode(wl_mode), .o_wr_valid(wr_valid), .o_wr_data(wr_data),
		.o_par_err(par_err), .o_crc_err(crc_err), .o_alert(d_alert));
	dat_link_sva u_dat_link_sva (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_persist(persist),
		.ck(lnk.ck), .dqs_line(lnk.dqs_line), .dqs_oe_n(lnk.dqs_oe_n), .par(lnk.par),
		.cmd(lnk.cmd), .alert_o(lnk.alert_o), .alert_oe_n(lnk.alert_oe_n),
		.alert_n(lnk.alert_n));
	initial
	begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk
	task automatic test_done();
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	// Blocked requests wait out a whole parity alert
	task automatic send(input logic [2:0] c, input logic [7:0] v, input logic bp, input logic bc);
		int n;
		@(negedge i_clock);
		cmd_valid = 1'b1;
		cmd = c;
		wdata = v;
		bad_par = bp;
		bad_crc = bc;
		for (n = 0; n < 1000 && cmd_ready !== 1'b1; n++)
			@(negedge i_clock);
		chk(cmd_ready === 1'b1, "command not taken");
		cmd_valid = 1'b0;
		bad_par = 1'b0;
		bad_crc = 1'b0;
	endtask : send
	task automatic wait_alert(input logic lvl, input int lim);
		for (int n = 0; n < lim && d_alert !== lvl; n++)
			@(negedge i_clock);
		chk(d_alert === lvl, "alert level not reached");
	endtask : wait_alert
	always @(negedge i_clock)
	begin
		if (crc_pend)
			chk(d_alert === 1'b1, "write check alert late");
		crc_pend = i_rst_n && crc_err === 1'b1;
		if (i_rst_n && (wr_valid || crc_err || par_err))
		begin
			got = {wr_valid ? 2'h1 : (crc_err ? 2'h2 : 2'h3), wr_valid ? wr_data : 8'h00};
			chk(exp_q.size() > 0 && got === exp_q[0], "device event mismatch");
			if (exp_q.size() > 0)
				void'(exp_q.pop_front());
		end
	end
	always @(posedge i_clock)
	begin
		cyc++;
		if (cyc >= 20000)
		begin
			err_count++;
			$display("ERROR %0t run did not finish", $time);
			test_done();
		end
	end
	initial
	begin
		i_rst_n = 1'b0;
		{cmd_valid, bad_par, bad_crc, persist, crc_pend} = 5'h00;
		cmd = 3'h0;
		wdata = 8'h00;
		wl_phase = 3'h0;
		err_count = 0;
		total_checks = 0;
		cyc = 0;
		void'($urandom(32'hFDB5ACDE));
		repeat (3) @(negedge i_clock);
		i_rst_n = 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			d = (i < 2) ? {8{i[0]}} : 8'($urandom());
			exp_q.push_back({2'h1, d});
			send(dat_pkg::CMD_WRITE, d, 1'b0, 1'b0);
		end
		exp_q.push_back({2'h2, 8'h00});
		send(dat_pkg::CMD_WRITE, 8'h5A, 1'b0, 1'b1);
		wait_alert(1'b1, 40);
		repeat (4) @(negedge i_clock);
		chk(h_alert === 1'b1, "host missed alert");
		wait_alert(1'b0, 200);
		// Second write lands inside the parity window
		exp_q.push_back({2'h3, 8'h00});
		send(dat_pkg::CMD_WRITE, 8'h33, 1'b1, 1'b0);
		send(dat_pkg::CMD_WRITE, 8'hC4, 1'b0, 1'b0);
		wait_alert(1'b1, 60);
		wait_alert(1'b0, 900);
		persist = 1'b1;
		exp_q.push_back({2'h3, 8'h00});
		send(dat_pkg::CMD_WRITE, 8'h96, 1'b1, 1'b0);
		wait_alert(1'b1, 60);
		d = 8'($urandom());
		exp_q.push_back({2'h1, d});
		send(dat_pkg::CMD_WRITE, d, 1'b0, 1'b0);
		chk(d_alert === 1'b0, "write taken during alert");
		persist = 1'b0;
		send(dat_pkg::CMD_WL_ON, 8'h00, 1'b0, 1'b0);
		for (int n = 0; n < 400 && wl_run !== 1'b1; n++)
			@(negedge i_clock);
		chk(wl_run === 1'b1 && wl_mode === 1'b1, "leveling not running");
		for (int p = 0; p < 8; p++)
		begin
			wl_phase = 3'(p);
			repeat (24) @(negedge i_clock);
			for (int n = 0; n < 9 && fb_valid !== 1'b1; n++)
				@(negedge i_clock);
			chk(fb_valid === 1'b1 && fb === (p < 4), "leveling sample");
		end
		send(dat_pkg::CMD_WL_OFF, 8'h00, 1'b0, 1'b0);
		repeat (16) @(negedge i_clock);
		chk(wl_run === 1'b0 && wl_mode === 1'b0, "leveling not left");
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_clock);
		i_rst_n = 1'b1;
		d = 8'($urandom());
		exp_q.push_back({2'h1, d});
		send(dat_pkg::CMD_WRITE, d, 1'b0, 1'b0);
		repeat (16) @(negedge i_clock);
		chk(exp_q.size() == 0, "device event missing");
		test_done();
	end
endmodule : dram_alert_and_leveling_timing_test
